// ===== core/sat_top.sv
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "sat_defs.svh"
module sat_top
	import sat_pkg::*;
#(
	parameter bit HAS_TLB = 1'b0
)(
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// processor side
	input  wire sat_req_t    cpu_req,
	output logic             cpu_ready,
	output logic [31:0]      cpu_rdata,
	output logic             cpu_addr_err,
	// memory side
	output sat_mem_t         mem,
	input  wire logic        mem_ack,
	input  wire logic [31:0] mem_rdata,
	// interrupt
	output logic             irq
);
	typedef enum logic [1:0] {SAT_IDLE, SAT_LOOK, SAT_PHASE, SAT_DONE} sat_state_t;

	// refuse a variant flag that the reset logic cannot serve
	if (HAS_TLB != 1'b0 && HAS_TLB != 1'b1) begin : g_bad_has_tlb
		$error("sat_top: bad HAS_TLB");
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [15:0] kseg01_w, next_kseg01_w;
	logic [7:0]  useg_w, next_useg_w;
	logic [3:0]  mapped_kernel_segment_w, next_mapped_kernel_segment_w;
	logic        ts_flag, next_ts_flag;
	logic [`SAT_IRQ_BITS-1:0] irq_stat, next_irq_stat;
	logic [`SAT_IRQ_BITS-1:0] irq_en, next_irq_en;
	logic [31:0] next_prdata;
	logic        next_pready, next_pslverr, next_irq;

	// ----------------------------------------------------------------
	// access engine state
	// ----------------------------------------------------------------
	sat_state_t  state, next_state;
	sat_req_t    req, next_req;
	sat_mem_t    next_mem;
	logic [1:0]  phase, next_phase;
	logic [31:0] rbuf, next_rbuf;
	logic        next_cpu_ready, next_cpu_addr_err;
	logic [31:0] next_cpu_rdata;
	logic        ev_err, ev_done;

	logic [31:0] x_paddr;
	sat_seg_t    x_seg;
	logic [1:0]  x_width;

	sat_xlate u_xlate (
		.pclk     (pclk),
		.presetn  (presetn),
		// lookup starts on the take edge so the result is ready in SAT_LOOK
		.vaddr    (state == SAT_IDLE ? cpu_req.addr : req.addr),
		.kseg01_w (kseg01_w),
		.useg_w   (useg_w),
		.mapped_kernel_segment_w  (mapped_kernel_segment_w),
		.paddr    (x_paddr),
		.seg      (x_seg),
		.width    (x_width)
	);

	wire logic setup  = psel && !penable;
	wire logic wr_acc = psel && penable && pwrite && pready;

	// ----------------------------------------------------------------
	// apb slave, no wait state: pready rises in the first access cycle
	// ----------------------------------------------------------------
	always_comb begin
		next_kseg01_w = kseg01_w;
		next_useg_w   = useg_w;
		next_mapped_kernel_segment_w  = mapped_kernel_segment_w;
		next_ts_flag  = ts_flag;
		next_irq_en   = irq_en;
		next_prdata   = prdata;
		next_pslverr  = 1'b0;
		next_pready   = 1'b0;
		next_irq_stat = irq_stat;
		if (setup) begin
			next_pready = 1'b1;
			next_prdata = 32'h0000_0000;
			unique case (paddr)
				`SAT_OFF_CTRL:     next_prdata = {31'h0, ts_flag};
				`SAT_OFF_STATUS:   next_prdata = {30'h0, state != SAT_IDLE, ts_flag};
				`SAT_OFF_KSEG01_W: next_prdata = {16'h0, kseg01_w};
				`SAT_OFF_USEG_W:   next_prdata = {24'h0, useg_w};
				`SAT_OFF_MAPPED_KERNEL_SEGMENT_W:  next_prdata = {28'h0, mapped_kernel_segment_w};
				`SAT_OFF_IRQ_STAT: next_prdata = {30'h0, irq_stat};
				`SAT_OFF_IRQ_CLR:  next_prdata = 32'h0000_0000;
				`SAT_OFF_IRQ_EN:   next_prdata = {30'h0, irq_en};
				default:           next_pslverr = 1'b1;
			endcase
		end
		if (wr_acc) begin
			unique case (paddr)
				`SAT_OFF_CTRL:     next_ts_flag = pwdata[`SAT_CTRL_TS_BIT];
				`SAT_OFF_KSEG01_W: next_kseg01_w = pwdata[15:0];
				`SAT_OFF_USEG_W:   next_useg_w = pwdata[7:0];
				`SAT_OFF_MAPPED_KERNEL_SEGMENT_W:  next_mapped_kernel_segment_w = pwdata[3:0];
				`SAT_OFF_IRQ_CLR:  next_irq_stat = irq_stat & ~pwdata[`SAT_IRQ_BITS-1:0];
				`SAT_OFF_IRQ_EN:   next_irq_en = pwdata[`SAT_IRQ_BITS-1:0];
				default:           next_irq_stat = irq_stat;
			endcase
		end
		// set wins over clear
		if (ev_err)
			next_irq_stat[`SAT_IRQ_ADDRERR] = 1'b1;
		if (ev_done)
			next_irq_stat[`SAT_IRQ_DONE] = 1'b1;
		next_irq = |(next_irq_stat & next_irq_en);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			kseg01_w <= `SAT_KSEG01_W_RST;
			useg_w   <= `SAT_USEG_W_RST;
			mapped_kernel_segment_w  <= `SAT_MAPPED_KERNEL_SEGMENT_W_RST;
			ts_flag  <= ~HAS_TLB;
			irq_stat <= '0;
			irq_en   <= '0;
			prdata   <= 32'h0000_0000;
			pready   <= 1'b0;
			pslverr  <= 1'b0;
			irq      <= 1'b0;
		end else begin
			kseg01_w <= next_kseg01_w;
			useg_w   <= next_useg_w;
			mapped_kernel_segment_w  <= next_mapped_kernel_segment_w;
			ts_flag  <= next_ts_flag;
			irq_stat <= next_irq_stat;
			irq_en   <= next_irq_en;
			prdata   <= next_prdata;
			pready   <= next_pready;
			pslverr  <= next_pslverr;
			irq      <= next_irq;
		end
	end

	// ----------------------------------------------------------------
	// access engine
	// ----------------------------------------------------------------
	function automatic logic [1:0] phases_of(input logic [1:0] w);
		unique case (w)
			`SAT_W8:  phases_of = 2'h3;
			`SAT_W16: phases_of = 2'h1;
			default:  phases_of = 2'h0;
		endcase
	endfunction

	always_comb begin
		next_state        = state;
		next_req          = req;
		next_mem          = mem;
		next_phase        = phase;
		next_rbuf         = rbuf;
		next_cpu_ready    = 1'b0;
		next_cpu_rdata    = cpu_rdata;
		next_cpu_addr_err = 1'b0;
		ev_err            = 1'b0;
		ev_done           = 1'b0;
		unique case (state)
			SAT_IDLE: begin
				// the edge that sees cpu_ready high closes the old request
				if (cpu_req.valid && !cpu_ready) begin
					next_req = cpu_req;
					if (cpu_req.user_mode && cpu_req.addr[31]) begin
						// no bus phase is issued for the faulting access
						next_cpu_addr_err = 1'b1;
						next_cpu_ready    = 1'b1;
						ev_err            = 1'b1;
					end else begin
						next_state = SAT_LOOK;
					end
				end
			end
			SAT_LOOK: begin
				// software sees a 32-bit memory whatever the port width
				next_phase      = phases_of(x_width);
				next_rbuf       = 32'h0000_0000;
				next_mem.valid  = 1'b1;
				next_mem.write  = req.write;
				next_mem.cacheable = (x_seg == SAT_SEG_CACHED) && !req.write;
				next_mem.addr   = x_paddr;
				next_mem.wdata  = req.wdata;
				next_mem.size   = x_width;
				next_state      = SAT_PHASE;
			end
			SAT_PHASE: begin
				if (mem_ack) begin
					unique case (mem.size)
						`SAT_W8:  next_rbuf = {mem_rdata[7:0], rbuf[31:8]};
						`SAT_W16: next_rbuf = {mem_rdata[15:0], rbuf[31:16]};
						default:  next_rbuf = mem_rdata;
					endcase
					if (phase == 2'h0) begin
						next_mem.valid = 1'b0;
						next_state     = SAT_DONE;
					end else begin
						// narrow port: step address and shift write data
						next_phase = phase - 2'h1;
						unique case (mem.size)
							`SAT_W8: begin
								next_mem.addr  = mem.addr + 32'h1;
								next_mem.wdata = {8'h00, mem.wdata[31:8]};
							end
							default: begin
								next_mem.addr  = mem.addr + 32'h2;
								next_mem.wdata = {16'h0000, mem.wdata[31:16]};
							end
						endcase
					end
				end
			end
			SAT_DONE: begin
				next_cpu_ready = 1'b1;
				next_cpu_rdata = rbuf;
				ev_done        = 1'b1;
				next_state     = SAT_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state        <= SAT_IDLE;
			req          <= '0;
			mem          <= '0;
			phase        <= 2'h0;
			rbuf         <= 32'h0000_0000;
			cpu_ready    <= 1'b0;
			cpu_rdata    <= 32'h0000_0000;
			cpu_addr_err <= 1'b0;
		end else begin
			state        <= next_state;
			req          <= next_req;
			mem          <= next_mem;
			phase        <= next_phase;
			rbuf         <= next_rbuf;
			cpu_ready    <= next_cpu_ready;
			cpu_rdata    <= next_cpu_rdata;
			cpu_addr_err <= next_cpu_addr_err;
		end
	end
endmodule
`default_nettype wire

// ===== common/sat_defs.svh
`ifndef SAT_DEFS_SVH
`define SAT_DEFS_SVH

// apb register byte offsets
`define SAT_OFF_CTRL     12'h000
`define SAT_OFF_STATUS   12'h004
`define SAT_OFF_KSEG01_W 12'h008
`define SAT_OFF_USEG_W   12'h00C
`define SAT_OFF_MAPPED_KERNEL_SEGMENT_W  12'h010
`define SAT_OFF_IRQ_STAT 12'h014
`define SAT_OFF_IRQ_CLR  12'h018
`define SAT_OFF_IRQ_EN   12'h01C

// width field encodings
`define SAT_W8  2'h0
`define SAT_W16 2'h1
`define SAT_W32 2'h2

// reset value of width registers: every subsegment 32 bits
`define SAT_KSEG01_W_RST 16'hAAAA
`define SAT_USEG_W_RST   8'hAA
`define SAT_MAPPED_KERNEL_SEGMENT_W_RST  4'hA

// status and ctrl bit positions
`define SAT_ST_TS_BIT    0
`define SAT_ST_BUSY_BIT  1
`define SAT_CTRL_TS_BIT  0

// interrupt bits
`define SAT_IRQ_ADDRERR  0
`define SAT_IRQ_DONE     1
`define SAT_IRQ_BITS     2

`endif

// ===== common/sat_pkg.sv
package sat_pkg;
	typedef enum logic [1:0] {
		SAT_SEG_USER,
		SAT_SEG_CACHED,
		SAT_SEG_UNCACHED,
		SAT_SEG_MAPPED
	} sat_seg_t;

	// processor side request
	typedef struct packed {
		logic        valid;
		logic        write;
		logic        user_mode;
		logic        fetch;
		logic [31:0] addr;
		logic [31:0] wdata;
		logic [3:0]  be;
	} sat_req_t;

	// memory bus phase
	typedef struct packed {
		logic        valid;
		logic        write;
		logic        cacheable;
		logic [31:0] addr;
		logic [31:0] wdata;
		logic [1:0]  size;
	} sat_mem_t;
endpackage

// ===== core/sat_xlate.sv
`timescale 1ns/1ps
`default_nettype none
`include "sat_defs.svh"
module sat_xlate
	import sat_pkg::*;
(
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// lookup
	input  wire logic [31:0] vaddr,
	input  wire logic [15:0] kseg01_w,
	input  wire logic [7:0]  useg_w,
	input  wire logic [3:0]  mapped_kernel_segment_w,
	// result, registered
	output logic [31:0]      paddr,
	output sat_seg_t         seg,
	output logic [1:0]       width
);
	sat_seg_t    next_seg;
	logic [31:0] next_paddr;
	logic [1:0]  next_width;

	always_comb begin
		next_paddr = vaddr;
		next_seg   = SAT_SEG_USER;
		next_width = `SAT_W32;
		// reserved areas fall through with their segment
		unique case (vaddr[31:29])
			3'h4: begin
				next_seg   = SAT_SEG_CACHED;
				next_paddr = {3'h0, vaddr[28:0]};
				next_width = kseg01_w[vaddr[28:26]*2 +: 2];
			end
			3'h5: begin
				next_seg   = SAT_SEG_UNCACHED;
				next_paddr = {3'h0, vaddr[28:0]};
				next_width = kseg01_w[vaddr[28:26]*2 +: 2];
			end
			3'h6, 3'h7: begin
				next_seg   = SAT_SEG_MAPPED;
				next_paddr = vaddr;
				next_width = mapped_kernel_segment_w[vaddr[29]*2 +: 2];
			end
			default: begin
				// mode does not enter, so kernel sees user mapping
				next_seg   = SAT_SEG_USER;
				next_paddr = {vaddr[30] ? 2'h2 : 2'h1, vaddr[29:0]};
				next_width = useg_w[vaddr[30:29]*2 +: 2];
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			paddr <= 32'h0000_0000;
			seg   <= SAT_SEG_USER;
			width <= `SAT_W32;
		end else begin
			paddr <= next_paddr;
			seg   <= next_seg;
			width <= next_width;
		end
	end
endmodule
`default_nettype wire

// ===== testbench/sat_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module sat_top_monitor
	import sat_pkg::*;
(
	// clock and reset
	input wire logic     pclk,
	input wire logic     presetn,
	// apb
	input wire logic     psel,
	input wire logic     penable,
	input wire logic     pready,
	// cpu and memory
	input wire logic     cpu_ready,
	input wire logic     cpu_addr_err,
	input wire sat_mem_t mem,
	input wire logic     mem_ack
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_apb; psel && !penable |=> pready; endproperty
	a_apb: assert property (p_apb) else $error("apb answer late");
	property p_err; cpu_addr_err |-> cpu_ready && !mem.valid; endproperty
	a_err: assert property (p_err) else $error("error reached bus");
	property p_size; mem.valid |-> mem.size != 2'h3; endproperty
	a_size: assert property (p_size) else $error("bad size");
	property p_gap; mem.valid |-> mem.addr[31:29] != 3'h1; endproperty
	a_gap: assert property (p_gap) else $error("gap address");
	property p_cache; mem.valid && mem.cacheable |-> mem.addr[31:29] == 3'h0; endproperty
	a_cache: assert property (p_cache) else $error("cacheable outside");
	property p_hold; mem.valid && !mem_ack |=> mem.valid && $stable(mem.addr) && $stable(mem.size); endproperty
	a_hold: assert property (p_hold) else $error("phase moved");
	property p_step8;
		mem.valid && mem_ack && mem.size == 2'h0 && mem.addr[1:0] != 2'h3 |=> mem.addr == $past(mem.addr) + 32'h1;
	endproperty
	a_step8: assert property (p_step8) else $error("byte step");
	property p_step16; mem.valid && mem_ack && mem.size == 2'h1 && !mem.addr[1] |=> mem.addr == $past(mem.addr) + 32'h2; endproperty
	a_step16: assert property (p_step16) else $error("half step");
	property p_done; cpu_ready && !cpu_addr_err |-> $past(mem_ack, 2); endproperty
	a_done: assert property (p_done) else $error("done early");
	c_err: cover property (cpu_addr_err);
	c_byte: cover property (mem_ack && mem.size == 2'h0);
	c_half: cover property (mem_ack && mem.size == 2'h1);
endmodule
bind sat_top sat_top_monitor i_sat_top_monitor (.pclk, .presetn, .psel, .penable, .pready, .cpu_ready,
	.cpu_addr_err, .mem, .mem_ack);
`default_nettype wire

// ===== testbench/sat_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module sat_mem_model
	import sat_pkg::*;
(
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// memory bus
	input wire sat_mem_t    mem,
	input wire logic [3:0]  dly,
	output logic            mem_ack,
	output logic [31:0]     mem_rdata,
	output logic            kern_sel
);
	logic [3:0] cnt;
	// top pattern 11x selects kernel-only devices
	assign kern_sel = mem.valid && mem.addr[31:30] == 2'h3;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 4'h0;
			mem_ack <= 1'h0;
			mem_rdata <= 32'h0;
		end else if (mem.valid && !mem_ack && cnt >= dly) begin
			// data echoes the address so each phase is told apart
			cnt <= 4'h0;
			mem_ack <= 1'h1;
			mem_rdata <= {mem.addr[15:0] + 16'h1, mem.addr[15:0]};
		end else begin
			// released data lines toggle, never hold the last value
			cnt <= (mem.valid && !mem_ack) ? cnt + 4'h1 : 4'h0;
			mem_ack <= 1'h0;
			mem_rdata <= ~mem_rdata;
		end
	end
endmodule
`default_nettype wire

// ===== testbench/sat_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "sat_defs.svh"
module sat_top_tb
	import sat_pkg::*;
;
	// flags: user, write, cacheable, error
	typedef struct packed {
		logic [3:0]  f;
		logic [31:0] a;
		logic [31:0] pa;
		logic [1:0]  sz;
	} sat_row_t;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, cpu_rdata, mem_rdata, rd, fa;
	logic pready, pslverr, cpu_ready, cpu_addr_err, mem_ack, irq, se, er, fc;
	logic [1:0] fs;
	logic [7:0] fw;
	logic [3:0] dly = 4'h0;
	sat_req_t cpu_req = '0;
	sat_mem_t mem;
	int err_total = 0, n_checks = 0, ph;
	sat_row_t rows [11];
	always #25 pclk = ~pclk;
	sat_top i_sat_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.cpu_req, .cpu_ready, .cpu_rdata, .cpu_addr_err, .mem, .mem_ack, .mem_rdata, .irq);
	sat_mem_model i_sat_mem_model (.pclk, .presetn, .mem, .dly, .mem_ack, .mem_rdata, .kern_sel());
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic complete_run();
		$display("checks=%0d mismatches=%0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, w, a, d};
		@(posedge pclk);
		penable <= 1'h1;
		for (int k = 0; k <= 50; k++) begin
			@(posedge pclk);
			if (pready) break;
			if (k == 50) begin
				err_total++;
				complete_run();
			end
		end
		{rd, se} = {prdata, pslverr};
		{psel, penable} <= 2'h0;
	endtask
	task automatic acc(input sat_row_t r);
		@(posedge pclk);
		cpu_req <= '{1'h1, r.f[2], r.f[3], 1'h0, r.a, 32'h3C5A96E1, 4'hF};
		ph = 0;
		for (int k = 0; k <= 200; k++) begin
			@(posedge pclk);
			if (mem.valid && mem_ack) begin
				if (ph == 0) {fa, fs, fc, fw} = {mem.addr, mem.size, mem.cacheable, mem.wdata[7:0]};
				ph++;
			end
			if (cpu_ready) break;
			if (k == 200) begin
				err_total++;
				complete_run();
			end
		end
		{er, rd} = {cpu_addr_err, cpu_rdata};
		cpu_req <= '0;
	endtask
	// reads come back low part first
	function automatic logic [31:0] exp_rd(input logic [31:0] a, input logic [1:0] s);
		if (s == 2'h0) return {a[7:0] + 8'h3, a[7:0] + 8'h2, a[7:0] + 8'h1, a[7:0]};
		if (s == 2'h1) return {a[15:0] + 16'h2, a[15:0]};
		return {a[15:0] + 16'h1, a[15:0]};
	endfunction
	initial begin
		rows = '{'{4'h2, 32'h80000010, 32'h00000010, 2'h0}, '{4'h0, 32'hA4000020, 32'h04000020, 2'h1},
			'{4'h4, 32'h88000000, 32'h08000000, 2'h2}, '{4'h8, 32'h00000100, 32'h40000100, 2'h2},
			'{4'hC, 32'h20000040, 32'h60000040, 2'h1}, '{4'h0, 32'h40000004, 32'h80000004, 2'h0},
			'{4'h8, 32'h7FFFFFF0, 32'hBFFFFFF0, 2'h2}, '{4'h0, 32'hC0000008, 32'hC0000008, 2'h1},
			'{4'h0, 32'hFFFFFFF0, 32'hFFFFFFF0, 2'h0}, '{4'h9, 32'h80000000, 32'h0, 2'h0},
			'{4'hD, 32'hC0000000, 32'h0, 2'h0}};
		repeat (10) @(posedge pclk);
		presetn <= 1'h1;
		apb(1'h0, `SAT_OFF_STATUS, 32'h0);
		chk(rd & 32'h1, 32'h1);
		apb(1'h0, `SAT_OFF_USEG_W, 32'h0);
		chk(rd, 32'hAA);
		apb(1'h1, `SAT_OFF_KSEG01_W, 32'hAAA4);
		apb(1'h1, `SAT_OFF_USEG_W, 32'h86);
		apb(1'h1, `SAT_OFF_MAPPED_KERNEL_SEGMENT_W, 32'h1);
		apb(1'h1, `SAT_OFF_IRQ_EN, 32'h3);
		foreach (rows[i]) begin
			dly <= i[0] ? 4'h3 : 4'h0;
			acc(rows[i]);
			chk({31'h0, er}, {31'h0, rows[i].f[0]});
			if (!rows[i].f[0]) begin
				chk(fa, rows[i].pa);
				chk({30'h0, fs}, {30'h0, rows[i].sz});
				chk(ph, 32'h4 >> rows[i].sz);
				chk({31'h0, fc}, {31'h0, rows[i].f[1]});
				chk(rows[i].f[2] ? {24'h0, fw} : rd, rows[i].f[2] ? 32'hE1 : exp_rd(rows[i].pa, rows[i].sz));
			end else
				chk(ph, 32'h0);
		end
		chk({31'h0, irq}, 32'h1);
		apb(1'h0, `SAT_OFF_IRQ_STAT, 32'h0);
		chk(rd, 32'h3);
		apb(1'h1, `SAT_OFF_IRQ_CLR, 32'h3);
		apb(1'h1, `SAT_OFF_IRQ_EN, 32'h1);
		acc(rows[0]);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, 32'h0);
		apb(1'h0, 12'hFF0, 32'h0);
		chk({31'h0, se}, 32'h1);
		presetn <= 1'h0;
		@(posedge pclk);
		chk({31'h0, mem.valid}, 32'h0);
		presetn <= 1'h1;
		apb(1'h0, `SAT_OFF_MAPPED_KERNEL_SEGMENT_W, 32'h0);
		chk(rd, 32'hA);
		complete_run();
	end
endmodule
`default_nettype wire
